// File: common/pscc_pkg.sv
// shared constants and types for the pin state, reset and clock control block
package pscc_pkg;
  // ------------------------------------------------------------
  // fixed values
  // ------------------------------------------------------------
  localparam logic [19:0] RESET_VECTOR = 20'hF_FFF0; // first fetch address
  localparam logic [7:0] NMI_TYPE = 8'h02; // vector type of the edge interrupt
  localparam logic [15:0] AD_RESET_VAL = 16'h0000; // shared lines value after reset
  localparam logic [2:0] UPPER_DATA_VAL = 3'h0; // upper lines in data phase
  localparam int CLK_PERIOD_NS = 10; // 100 MHz internal clock
  localparam int PD_EXIT_NS = 100000; // wake delay, stands for the capacitor
  localparam int PD_EXIT_CYC = PD_EXIT_NS / CLK_PERIOD_NS; // cycles of wake delay
  localparam int SYNC_STAGES = 3; // flops in each pin synchroniser
  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PSCC_BUS_IDLE = 2'b00,
    PSCC_BUS_ADDR = 2'b01,
    PSCC_BUS_DATA = 2'b10,
    PSCC_BUS_END = 2'b11
  } pscc_bus_t;
  typedef enum logic [1:0] {
    PSCC_PM_RUN = 2'b00,
    PSCC_PM_IDLE = 2'b01,
    PSCC_PM_DOWN = 2'b10,
    PSCC_PM_WAKE = 2'b11
  } pscc_pm_t;
endpackage

// File: src/pscc_sync.sv
// three-flop pin synchroniser with agreement filter
module pscc_sync #(
  parameter int W = 1, // number of pins
  parameter logic [W-1:0] INIT = '0 // level held during reset
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  logic [W-1:0] s1_r; // metastable stage, read only by s2_r
  logic [W-1:0] s2_r; // second stage
  logic [W-1:0] s3_r; // third stage
  logic [W-1:0] q_nxt; // filtered next level
  genvar i;
  // a bit changes only when stage two and three agree
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
    end
  endgenerate
  // shift chain and filtered output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
    end
  end
endmodule

// File: src/pscc_top.sv
// pin state, reset, bus clock and bus phase control of the processor
module pscc_top #(
  parameter int PD_EXIT_CYC = pscc_pkg::PD_EXIT_CYC // wake delay in cycles
) (
  input wire logic clk, // input clock, twice the bus rate
  input wire logic rstn, // power-on reset
  input wire logic reset_input_n, // reset pin, active low
  input wire logic nmi_in, // edge interrupt pin
  input wire logic test_busy_n, // test pin, active low
  input wire logic [15:0] muxed_addr_data_lines_i, // shared lines read back
  input wire logic addr19_float_select_i, // addr19 / float select read back
  input wire logic powerdown_exit_timer_pin_i, // timer pin read back
  input wire logic hold_ack, // core granted the bus away
  input wire logic idle_req, // core asks for idle
  input wire logic pd_req, // core asks for powerdown
  input wire logic nmi_ack, // core took the interrupt
  input wire logic wait_active, // core executes the wait-for-test
  input wire logic cyc_req, // core asks for a bus cycle
  input wire logic [19:0] cyc_addr, // cycle address
  input wire logic cyc_write, // 1 write, 0 read
  input wire logic [15:0] cyc_wdata, // write data
  output logic bus_clock_output, // half rate bus clock
  output logic crystal_drive_output, // oscillator drive
  output logic reset_status_output, // high while in reset
  output logic ale, // address latch strobe
  output logic [15:0] muxed_addr_data_lines_o, // shared lines drive value
  output logic muxed_addr_data_lines_oe_n, // low while driving
  output logic [2:0] upper_address_lines_o, // address 18:16
  output logic upper_address_lines_oe_n, // low while driving
  output logic addr19_float_select_o, // address 19
  output logic addr19_float_select_oe_n, // low while driving
  output logic powerdown_exit_timer_pin_o, // timer pin drive value
  output logic powerdown_exit_timer_pin_oe_n, // low while driving
  output logic all_pins_float_mode, // float test mode in force
  output logic cyc_done, // one-cycle pulse, cycle finished
  output logic [15:0] cyc_rdata, // read data, valid with cyc_done
  output logic fetch_start, // one-cycle pulse after reset release
  output logic [19:0] fetch_addr, // first fetch address
  output logic nmi_pending, // latched edge interrupt
  output logic [7:0] nmi_type, // vector type while pending
  output logic wait_release // one-cycle pulse ending the wait
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (PD_EXIT_CYC < 1) begin : g_bad_pd
    $error("PD_EXIT_CYC must be at least 1");
  end
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pins_s; // reset_n, nmi, test_n, addr19
  // synchronise async pins
  // idle levels: reset held, interrupt low, test high, addr19 high,
  // so no false interrupt edge or test low shows after power-on
  pscc_sync #(.W(4), .INIT(4'h3)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({reset_input_n, nmi_in, test_busy_n, addr19_float_select_i}),
    .q(pins_s)
  );
  wire in_rst = ~pins_s[3]; // reset pin held
  wire nmi_s = pins_s[2]; // synchronised interrupt
  wire test_n_s = pins_s[1]; // synchronised test
  wire a19_s = pins_s[0]; // synchronised float select
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pscc_pkg::pscc_bus_t bus_r, bus_nxt; // bus phase
  pscc_pkg::pscc_pm_t pm_r, pm_nxt; // power mode
  logic nmi_d_r; // previous interrupt level
  logic boot_r; // fetch owed after release
  logic [$clog2(PD_EXIT_CYC+1)-1:0] pd_cnt_r; // wake counter
  logic float_r; // float test mode
  logic a19_seen_r; // addr19 seen low in reset
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire nmi_edge = nmi_s & ~nmi_d_r; // rising edge only
  wire nmi_keep = ~in_rst & (nmi_edge | (nmi_pending & ~nmi_ack)); // pending next level
  wire frz = (pm_r == pscc_pkg::PSCC_PM_DOWN) | (pm_r == pscc_pkg::PSCC_PM_WAKE);
  wire idle = pm_r == pscc_pkg::PSCC_PM_IDLE;
  // bus phases step on the bus clock falling edge
  wire ce = bus_clock_output & ~in_rst & ~frz;
  wire drv_bus = ~hold_ack & ~in_rst & ~idle; // may change the bus pins
  wire pd_done = pd_cnt_r == '0;
  // ------------------------------------------------------------
  // power mode machine
  // ------------------------------------------------------------
  always_comb begin
    pm_nxt = pm_r;
    unique case (pm_r)
      pscc_pkg::PSCC_PM_RUN: begin
        if (pd_req && bus_r == pscc_pkg::PSCC_BUS_IDLE) begin
          pm_nxt = pscc_pkg::PSCC_PM_DOWN;
        end else if (idle_req && bus_r == pscc_pkg::PSCC_BUS_IDLE) begin
          pm_nxt = pscc_pkg::PSCC_PM_IDLE;
        end
      end
      pscc_pkg::PSCC_PM_IDLE: begin
        // interrupt or core release ends idle
        if (nmi_edge || !idle_req) begin
          pm_nxt = pscc_pkg::PSCC_PM_RUN;
        end
      end
      pscc_pkg::PSCC_PM_DOWN: begin
        if (nmi_edge) begin
          pm_nxt = pscc_pkg::PSCC_PM_WAKE;
        end
      end
      pscc_pkg::PSCC_PM_WAKE: begin
        if (pd_done) begin
          pm_nxt = pscc_pkg::PSCC_PM_RUN;
        end
      end
    endcase
  end
  // power mode register, reset pin wins over everything
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_r <= pscc_pkg::PSCC_PM_RUN;
    end else if (in_rst) begin
      pm_r <= pscc_pkg::PSCC_PM_RUN;
    end else begin
      pm_r <= pm_nxt;
    end
  end
  // wake counter loads on entry, counts in wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_cnt_r <= '0;
    end else if (pm_r != pscc_pkg::PSCC_PM_WAKE) begin
      pd_cnt_r <= ($bits(pd_cnt_r))'(PD_EXIT_CYC - 1);
    end else if (!pd_done) begin
      pd_cnt_r <= pd_cnt_r - 1'b1;
    end
  end
  // ------------------------------------------------------------
  // bus phase machine
  // ------------------------------------------------------------
  always_comb begin
    bus_nxt = bus_r;
    unique case (bus_r)
      pscc_pkg::PSCC_BUS_IDLE: begin
        if (cyc_req && drv_bus && pm_r == pscc_pkg::PSCC_PM_RUN) begin
          bus_nxt = pscc_pkg::PSCC_BUS_ADDR;
        end
      end
      pscc_pkg::PSCC_BUS_ADDR: bus_nxt = pscc_pkg::PSCC_BUS_DATA;
      pscc_pkg::PSCC_BUS_DATA: bus_nxt = pscc_pkg::PSCC_BUS_END;
      pscc_pkg::PSCC_BUS_END: bus_nxt = pscc_pkg::PSCC_BUS_IDLE;
    endcase
  end
  // reset aborts any cycle at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_r <= pscc_pkg::PSCC_BUS_IDLE;
    end else if (in_rst) begin
      bus_r <= pscc_pkg::PSCC_BUS_IDLE;
    end else if (ce) begin
      bus_r <= bus_nxt;
    end
  end
  // ------------------------------------------------------------
  // pin next values
  // ------------------------------------------------------------
  // pins take the next phase only on the stepping edge, else the current one,
  // so the address stands for the whole address phase
  wire [1:0] bus_pin = ce ? bus_nxt : bus_r;
  wire ph_addr = bus_pin == pscc_pkg::PSCC_BUS_ADDR;
  wire ph_data = bus_pin == pscc_pkg::PSCC_BUS_DATA;
  wire ph_end = bus_pin == pscc_pkg::PSCC_BUS_END;
  wire [15:0] ad_nxt = ph_addr ? cyc_addr[15:0] : (ph_data ? cyc_wdata : muxed_addr_data_lines_o);
  // lines released for reads and in reset
  wire ad_oe_n_nxt = in_rst | hold_ack | float_r | ~(ph_addr | (cyc_write & (ph_data | ph_end)));
  // upper lines zero outside the address phase
  wire [3:0] up_nxt = ph_addr ? cyc_addr[19:16] : {1'b0, pscc_pkg::UPPER_DATA_VAL};
  wire up_oe_n_nxt = in_rst | hold_ack | float_r; // weak pull-up is the pad's
  // ------------------------------------------------------------
  // clock outputs
  // ------------------------------------------------------------
  // toggle bus clock, held low in reset so release realigns it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_clock_output <= 1'b0;
      crystal_drive_output <= 1'b0;
    end else if (in_rst) begin
      bus_clock_output <= 1'b0;
      crystal_drive_output <= ~crystal_drive_output;
    end else if (!frz) begin
      bus_clock_output <= ~bus_clock_output;
      crystal_drive_output <= ~crystal_drive_output;
    end
  end
  // ------------------------------------------------------------
  // float mode capture
  // ------------------------------------------------------------
  // addr19 low during reset selects float mode at release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a19_seen_r <= 1'b0;
      float_r <= 1'b0;
    end else if (in_rst) begin
      // last level before release decides; early samples may still show our own drive
      a19_seen_r <= ~a19_s;
      float_r <= 1'b0;
    end else begin
      a19_seen_r <= 1'b0;
      float_r <= float_r | a19_seen_r;
    end
  end
  // ------------------------------------------------------------
  // bus pins, frozen in powerdown
  // ------------------------------------------------------------
  // every pin holds during powerdown and wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      muxed_addr_data_lines_o <= pscc_pkg::AD_RESET_VAL;
      muxed_addr_data_lines_oe_n <= 1'b1;
      upper_address_lines_o <= pscc_pkg::UPPER_DATA_VAL;
      addr19_float_select_o <= 1'b0;
      upper_address_lines_oe_n <= 1'b1;
      addr19_float_select_oe_n <= 1'b1;
      ale <= 1'b0;
    end else if (!frz) begin
      // idle keeps the shared lines as they were
      if (!idle) begin
        muxed_addr_data_lines_o <= ad_nxt;
        muxed_addr_data_lines_oe_n <= ad_oe_n_nxt;
      end
      if (ce) begin
        upper_address_lines_o <= up_nxt[2:0];
        addr19_float_select_o <= up_nxt[3];
      end
      upper_address_lines_oe_n <= up_oe_n_nxt;
      addr19_float_select_oe_n <= up_oe_n_nxt;
      // strobe high for the address phase
      ale <= ~in_rst & ~float_r & ph_addr;
    end
  end
  // status and timer pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_status_output <= 1'b1;
      powerdown_exit_timer_pin_o <= 1'b1;
      powerdown_exit_timer_pin_oe_n <= 1'b1;
      all_pins_float_mode <= 1'b0;
    end else if (!frz || in_rst) begin
      // status follows the reset pin, low in hold
      reset_status_output <= in_rst & ~float_r;
      powerdown_exit_timer_pin_o <= 1'b1;
      // timer pin driven high in idle, floats in reset
      powerdown_exit_timer_pin_oe_n <= ~(idle & ~in_rst & ~float_r);
      all_pins_float_mode <= float_r;
    end
  end
  // ------------------------------------------------------------
  // core side events
  // ------------------------------------------------------------
  // cycle end, read data, boot fetch, interrupt latch, wait release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_done <= 1'b0;
      cyc_rdata <= '0;
      boot_r <= 1'b1;
      fetch_start <= 1'b0;
      fetch_addr <= pscc_pkg::RESET_VECTOR;
      nmi_d_r <= 1'b0;
      nmi_pending <= 1'b0;
      nmi_type <= '0;
      wait_release <= 1'b0;
    end else begin
      cyc_done <= ce & (bus_r == pscc_pkg::PSCC_BUS_END);
      // read data taken on the bus clock edge
      if (ce && bus_r == pscc_pkg::PSCC_BUS_DATA && !cyc_write) begin
        cyc_rdata <= muxed_addr_data_lines_i;
      end
      // first fetch from vector after release
      boot_r <= in_rst | (boot_r & ~ce);
      fetch_start <= boot_r & ce;
      fetch_addr <= pscc_pkg::RESET_VECTOR;
      nmi_d_r <= nmi_s;
      nmi_pending <= nmi_keep;
      nmi_type <= nmi_keep ? pscc_pkg::NMI_TYPE : 8'h00;
      // wait ends when test reads low
      wait_release <= wait_active & ~test_n_s & ~wait_release & ~in_rst;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_clk_toggle;
    !in_rst && !frz |=> bus_clock_output != $past(bus_clock_output);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("bus clock did not toggle");
  property p_rst_abort;
    in_rst |=> bus_r == pscc_pkg::PSCC_BUS_IDLE ##1 muxed_addr_data_lines_oe_n;
  endproperty
  a_rst_abort: assert property (p_rst_abort) else $error("cycle not aborted in reset");
  property p_fetch;
    $fell(in_rst) |-> ##[1:4] fetch_start && fetch_addr == pscc_pkg::RESET_VECTOR;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch after reset release");
  property p_reset_status_output;
    in_rst && !float_r |=> reset_status_output;
  endproperty
  a_reset_status_output: assert property (p_reset_status_output) else $error("reset status low in reset");
  property p_float;
    all_pins_float_mode && !frz |-> muxed_addr_data_lines_oe_n && upper_address_lines_oe_n
      && powerdown_exit_timer_pin_oe_n && !ale;
  endproperty
  a_float: assert property (p_float) else $error("pin driven in float mode");
  property p_hold;
    hold_ack && !in_rst && !frz |=> muxed_addr_data_lines_oe_n && !reset_status_output;
  endproperty
  a_hold: assert property (p_hold) else $error("bus driven during hold");
  property p_pd_freeze;
    frz && !in_rst |=> $stable(muxed_addr_data_lines_o) && $stable(bus_clock_output) && $stable(ale);
  endproperty
  a_pd_freeze: assert property (p_pd_freeze) else $error("pin moved in powerdown");
  property p_idle_timer;
    idle && !in_rst && !float_r ##1 idle |-> !powerdown_exit_timer_pin_oe_n && powerdown_exit_timer_pin_o;
  endproperty
  a_idle_timer: assert property (p_idle_timer) else $error("timer pin not high in idle");
  property p_upper_zero;
    ce && bus_r == pscc_pkg::PSCC_BUS_ADDR |=> upper_address_lines_o == pscc_pkg::UPPER_DATA_VAL;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lines not zero in data");
  property p_nmi;
    nmi_edge && !in_rst |=> nmi_pending && nmi_type == pscc_pkg::NMI_TYPE;
  endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt edge lost");
endmodule

// File: verif/pscc_mem_model.sv
// far-side model: address latch, memory answering reads, pin pulls
module pscc_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ale,
  input wire logic [15:0] lines_o,
  input wire logic lines_oe_n,
  input wire logic [2:0] upper_o,
  input wire logic a19_o,
  input wire logic a19_oe_n,
  input wire logic timer_o,
  input wire logic timer_oe_n,
  input wire logic float_sel_n, // bench asks for float test when low
  output logic [15:0] line_bus, // resolved shared lines
  output logic a19_line, // resolved addr19 pin
  output logic timer_line, // resolved timer pin
  output logic [19:0] latched_addr // what the external latch holds
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] last_r; // last level seen on the shared lines
  logic [2:0] drive_r; // clocks left in the read answer window
  logic [15:0] rd_word; // word a read returns
  assign rd_word = latched_addr[15:0] ^ 16'h5a5a;
  // released lines show the inverse of the last level, so a stale value never matches
  assign line_bus = !lines_oe_n ? lines_o : (drive_r != 3'h0 ? rd_word : ~last_r);
  // weak pull-up only
  // upper lines never pulled low; addr19 low only on request
  assign a19_line = !a19_oe_n ? a19_o : float_sel_n;
  // capacitor held discharged while the pin floats
  assign timer_line = !timer_oe_n ? timer_o : 1'b0;
  // latch follows while the strobe is high, memory answers after it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_r <= 16'h0000;
      drive_r <= 3'h0;
      latched_addr <= 20'h0_0000;
    end else begin
      last_r <= line_bus;
      if (ale) begin
        latched_addr <= {a19_o, upper_o, lines_o};
        drive_r <= 3'h6;
      end else if (drive_r != 3'h0) begin
        drive_r <= drive_r - 3'h1;
      end
    end
  end
endmodule

// File: verif/pscc_top_tb.sv
// self-checking bench for the pin state, reset and clock control block
module pscc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, reset_input_n, nmi_in, test_busy_n, hold_ack, idle_req, pd_req;
  logic nmi_ack, wait_active, cyc_req, cyc_write, float_sel_n;
  logic [19:0] cyc_addr, fetch_addr, latched_addr;
  logic [15:0] cyc_wdata, line_bus, lines_o, cyc_rdata;
  logic [2:0] upper_o;
  logic a19_line, timer_line, lines_oe_n, upper_oe_n, a19_o, a19_oe_n, timer_o, timer_oe_n;
  logic bus_clock_output, crystal_drive_output, reset_status_output, ale, all_pins_float_mode;
  logic cyc_done, fetch_start, nmi_pending, wait_release;
  logic [7:0] nmi_type;
  int error_cnt, cmp_count;
  // short wake delay keeps the run brief
  pscc_top #(.PD_EXIT_CYC(8)) uut (
    .clk, .rstn, .reset_input_n, .nmi_in, .test_busy_n, .hold_ack, .idle_req, .pd_req,
    .nmi_ack, .wait_active, .cyc_req, .cyc_addr, .cyc_write, .cyc_wdata,
    .muxed_addr_data_lines_i(line_bus), .addr19_float_select_i(a19_line),
    .powerdown_exit_timer_pin_i(timer_line), .bus_clock_output, .crystal_drive_output,
    .reset_status_output, .ale, .muxed_addr_data_lines_o(lines_o),
    .muxed_addr_data_lines_oe_n(lines_oe_n), .upper_address_lines_o(upper_o),
    .upper_address_lines_oe_n(upper_oe_n), .addr19_float_select_o(a19_o),
    .addr19_float_select_oe_n(a19_oe_n), .powerdown_exit_timer_pin_o(timer_o),
    .powerdown_exit_timer_pin_oe_n(timer_oe_n), .all_pins_float_mode, .cyc_done, .cyc_rdata,
    .fetch_start, .fetch_addr, .nmi_pending, .nmi_type, .wait_release
  );
  pscc_mem_model mem (
    .clk, .rstn, .ale, .lines_o, .lines_oe_n, .upper_o, .a19_o, .a19_oe_n, .timer_o,
    .timer_oe_n, .float_sel_n, .line_bus, .a19_line, .timer_line, .latched_addr
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset pin held; no cycle may complete meanwhile
  task automatic pin_reset(input logic sel_n);
    reset_input_n = 0;
    float_sel_n = sel_n;
    repeat (8) begin
      tick(1);
      chk(cyc_done, 0);
    end
    chk(reset_status_output, 1);
    chk({lines_oe_n, upper_oe_n, a19_oe_n, timer_oe_n}, 4'hf);
    chk({bus_clock_output, ale}, 0);
    float_sel_n = 1;
    reset_input_n = 1;
  endtask
  task automatic wait_fetch();
    for (int i = 0; i < 20 && fetch_start !== 1; i++) tick(1);
    chk(fetch_start, 1);
    chk(fetch_addr, 20'hF_FFF0);
  endtask
  // bus clock must flip on every internal clock
  task automatic clk_runs();
    logic p;
    p = bus_clock_output;
    repeat (4) begin
      tick(1);
      chk(bus_clock_output, {~p});
      p = bus_clock_output;
    end
  endtask
  task automatic no_done(input int n);
    repeat (n) begin
      tick(1);
      chk(cyc_done, 0);
    end
  endtask
  // one bus cycle, pins watched every clock
  task automatic bus_cyc(input logic [19:0] addr, input logic wr, input logic [15:0] wd);
    int na;
    na = 0;
    cyc_addr = addr;
    cyc_write = wr;
    cyc_wdata = wd;
    cyc_req = 1;
    for (int i = 0; i < 30 && cyc_done !== 1; i++) begin
      tick(1);
      if (ale === 1) begin
        na++;
        chk({lines_oe_n, upper_oe_n, a19_oe_n, a19_o, upper_o, lines_o}, {3'b000, addr});
      end else if (na > 0) begin
        if (upper_oe_n === 0) chk({a19_o, upper_o}, 0);
        if (wr && lines_oe_n === 0) chk(lines_o, wd);
      end
    end
    cyc_req = 0;
    chk(cyc_done, 1);
    chk(na, 2);
    chk(latched_addr, addr);
    if (!wr) chk(cyc_rdata, addr[15:0] ^ 16'h5a5a);
    // let an edge pass so a following call never re-raises the request at once
    tick(1);
  endtask
  // ----------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------
  // oscillator at twice bus rate
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // whole run is well under 2000 clocks
  initial begin
    #50us;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    logic [31:0] snap;
    logic p;
    {nmi_in, hold_ack, idle_req, pd_req, nmi_ack, wait_active, cyc_req, cyc_write} = 0;
    {test_busy_n, float_sel_n} = 2'b11;
    cyc_addr = 20'h0_0000;
    cyc_wdata = 16'h0000;
    rstn = 0;
    reset_input_n = 0;
    error_cnt = 0;
    cmp_count = 0;
    tick(5);
    rstn = 1;
    pin_reset(1);
    wait_fetch();
    clk_runs();
    // back-to-back write and reads, the last one at the top address
    bus_cyc(20'hA_1234, 1, 16'hBEEF);
    bus_cyc(20'h5_8001, 0, 16'h0000);
    bus_cyc(20'hF_FFFF, 0, 16'h0000);
    // hold: lines float, status low, request waits
    hold_ack = 1;
    tick(4);
    chk({lines_oe_n, upper_oe_n, a19_oe_n, reset_status_output}, 4'b1110);
    clk_runs();
    cyc_addr = 20'h0_0042;
    cyc_req = 1;
    no_done(16);
    hold_ack = 0;
    bus_cyc(20'h0_0042, 0, 16'h0000);
    // idle: timer pin high, clocks run
    idle_req = 1;
    tick(6);
    chk({timer_oe_n, timer_o, reset_status_output}, 3'b010);
    clk_runs();
    idle_req = 0;
    tick(2);
    // edge interrupt latched until taken
    nmi_in = 1;
    for (int i = 0; i < 10 && nmi_pending !== 1; i++) tick(1);
    chk({nmi_pending, nmi_type}, 9'h102);
    nmi_in = 0;
    nmi_ack = 1;
    tick(1);
    nmi_ack = 0;
    tick(2);
    chk(nmi_pending, 0);
    // wait instruction stalls while test pin high
    wait_active = 1;
    repeat (8) begin
      tick(1);
      chk(wait_release, 0);
    end
    test_busy_n = 0;
    for (int i = 0; i < 10 && wait_release !== 1; i++) tick(1);
    chk(wait_release, 1);
    wait_active = 0;
    test_busy_n = 1;
    // powerdown freezes pins; exit waits for the timer
    pd_req = 1;
    tick(4);
    pd_req = 0;
    snap = {bus_clock_output, crystal_drive_output, ale, lines_oe_n, upper_oe_n, timer_oe_n, lines_o};
    repeat (6) begin
      tick(1);
      chk({bus_clock_output, crystal_drive_output, ale, lines_oe_n, upper_oe_n, timer_oe_n, lines_o}, snap);
    end
    nmi_in = 1;
    repeat (8) begin
      tick(1);
      chk({bus_clock_output, crystal_drive_output}, snap[21:20]);
    end
    p = bus_clock_output;
    for (int i = 0; i < 20 && bus_clock_output === p; i++) tick(1);
    chk(bus_clock_output, {~p});
    nmi_in = 0;
    nmi_ack = 1;
    tick(1);
    nmi_ack = 0;
    // reset in the middle of a cycle aborts it
    cyc_addr = 20'h1_2345;
    cyc_write = 1;
    cyc_wdata = 16'h0F0F;
    cyc_req = 1;
    for (int i = 0; i < 10 && ale !== 1; i++) tick(1);
    cyc_req = 0;
    pin_reset(1);
    wait_fetch();
    // float test selected during reset
    pin_reset(0);
    tick(8);
    chk(all_pins_float_mode, 1);
    chk({lines_oe_n, upper_oe_n, a19_oe_n, timer_oe_n}, 4'hf);
    p = crystal_drive_output;
    tick(1);
    chk(crystal_drive_output, {~p});
    finish_test();
  end
endmodule
